// File: verilog/itp_top.sv
// Interrupt test control, banked test registers and priority promotion.
// Assumes the CPU core supplies mode and mask levels on clk_i and
// requests vectors with a one-cycle strobe; request pins are asynchronous.
// Function
// - Override bit writable only special, both masks
// - Override clear: writes ignored, reads live
// - Override set: decoder fed by test bits
// - Pending requests kept when override sets
// - Four-bit selector picks bank, always RW
// - Bank reads only special, else zero
// - Bank writes need special, override, I mask
// - Bit index = vector low byte/2
// - Override: requests only from test bits
// - One bank per eight interrupts, shared address
// - Selector F: bits 2:0 only, rest zero
// - Unimplemented bank: no write, reads zero
// - Promotion register writable only under I mask
// - Promoted source outranks other maskable ones
// - Bad promotion byte defaults to pin interrupt
// - Vector request returns highest pending now
// - Maskable sources descend by vector address
// - Never pending: software interrupt vector
`timescale 1ns/10ps
`default_nettype none
module itp_top #(
   parameter int NUM_BANKS = 16
) (
   input  wire logic                      clk_i,
   input  wire logic                      arst_n_i,
   input  wire itp_pkg::itp_bus_t         bus_i,
   output logic                    [7:0]  rdata_o,
   input  wire itp_pkg::itp_cpu_t         cpu_i,
   input  wire logic [NUM_BANKS*8-1:0]    irq_pins_i,
   input  wire logic                      vec_req_i,
   output logic                    [7:0]  vec_o,
   output logic                           vec_valid_o,
   output logic                           pending_o
);
   localparam int N = NUM_BANKS * 8;

   // The selector is four bits wide, so more banks could never be reached
   if (NUM_BANKS < 1 || NUM_BANKS > itp_pkg::ITP_BANKS_MAX) begin : g_bad_banks
      $error("NUM_BANKS out of range");
   end

   typedef struct packed {
      logic         override_en;
      logic [3:0]   sel;
      logic [N-1:0] test_bits;
      logic [7:0]   promote;
      logic [7:0]   rdata;
      logic [7:0]   vec;
      logic         vec_valid;
      logic [7:0]   last_vec;
   } itp_state_t;

   itp_state_t st_reg;
   itp_state_t st_next;
   logic [N-1:0] live_req;
   logic [N-1:0] dec_req;
   logic         dec_any;
   logic [7:0]   dec_vec;

   // Mask of bits that exist in a bank; top bank stops below the software interrupt vector
   function automatic logic [7:0] bank_mask(input logic [3:0] s);
      if (int'(s) >= NUM_BANKS) begin
         bank_mask = 8'h00;
      end else if (s == itp_pkg::ITP_TOP_BANK) begin
         bank_mask = itp_pkg::ITP_TOP_BANK_MASK;
      end else begin
         bank_mask = 8'hff;
      end
   endfunction : bank_mask

   function automatic logic [7:0] bank_of(input logic [N-1:0] v, input logic [3:0] s);
      bank_of = 8'h00;
      for (int b = 0; b < NUM_BANKS; b++) begin
         if (int'(s) == b) begin
            bank_of = v[b*8 +: 8];
         end
      end
   endfunction : bank_of

   itp_sync #(.W(N)) u_sync (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .async_i  (irq_pins_i),
      .sync_o   (live_req)
   );

   // Decoder sees test bits only while overridden
   assign dec_req = st_reg.override_en ? st_reg.test_bits : live_req;

   itp_prio_dec #(.N(N)) u_dec (
      .req_i     (dec_req),
      .promote_i (st_reg.promote),
      .any_o     (dec_any),
      .vec_o     (dec_vec)
   );

   logic       wr_ctl;
   logic       wr_bank;
   logic       wr_prom;
   logic [7:0] bmask;
   logic [7:0] bank_val;
   logic       ctl_ok;
   logic       bank_ok;
   logic       prom_ok;
   logic [7:0] bank_now;

   // Write permissions are plain level decodes of the core's mode and masks, plus the override bit for bank writes
   assign ctl_ok   = cpu_i.special_mode && cpu_i.i_mask && cpu_i.x_mask;
   assign bank_ok  = st_reg.override_en && cpu_i.special_mode && cpu_i.i_mask;
   assign prom_ok  = cpu_i.i_mask;
   // Selected bank in a special mode, without the bmask that software reads apply
   assign bank_now = st_reg.override_en ? bank_of(st_reg.test_bits, st_reg.sel)
                                        : bank_of(live_req, st_reg.sel);

   always_comb begin
      st_next   = st_reg;
      bmask     = bank_mask(st_reg.sel);
      wr_ctl    = bus_i.wr && bus_i.addr == itp_pkg::ITP_TEST_CONTROL_OFS;
      wr_bank   = bus_i.wr && bus_i.addr == itp_pkg::ITP_TEST_BANK_OFS;
      wr_prom   = bus_i.wr && bus_i.addr == itp_pkg::ITP_PROMOTE_OFS;
      bank_val  = 8'h00;

      if (wr_ctl) begin
         st_next.sel = bus_i.wdata[itp_pkg::ITP_SEL_MSB:0];
         if (ctl_ok) begin
            st_next.override_en = bus_i.wdata[itp_pkg::ITP_OVERRIDE_BIT];
            // Capture live state so pending requests survive the switch
            if (bus_i.wdata[itp_pkg::ITP_OVERRIDE_BIT] && !st_reg.override_en) begin
               st_next.test_bits = live_req;
            end
         end
      end

      if (wr_bank && bank_ok) begin
         for (int b = 0; b < NUM_BANKS; b++) begin
            if (int'(st_reg.sel) == b) begin
               st_next.test_bits[b*8 +: 8] = bus_i.wdata & bmask;
            end
         end
      end

      if (wr_prom && prom_ok) begin
         st_next.promote = bus_i.wdata;
      end

      st_next.rdata = 8'h00;
      if (bus_i.rd) begin
         case (bus_i.addr)
            itp_pkg::ITP_TEST_CONTROL_OFS: begin
               st_next.rdata = {3'h0, st_reg.override_en, st_reg.sel};
            end
            itp_pkg::ITP_TEST_BANK_OFS: begin
               bank_val = st_reg.override_en ? bank_of(st_reg.test_bits, st_reg.sel)
                                             : bank_of(live_req, st_reg.sel);
               st_next.rdata = cpu_i.special_mode ? (bank_val & bmask) : 8'h00;
            end
            itp_pkg::ITP_PROMOTE_OFS: begin
               st_next.rdata = st_reg.promote;
            end
            default: begin
               st_next.rdata = 8'h00;
            end
         endcase
      end

      st_next.vec_valid = vec_req_i;
      if (vec_req_i) begin
         // Vanished request falls back to the last valid vector
         st_next.vec = dec_any ? dec_vec : st_reg.last_vec;
      end
      if (dec_any) begin
         st_next.last_vec = dec_vec;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_reg             <= '0;
         st_reg.override_en <= itp_pkg::ITP_OVERRIDE_RESET;
         st_reg.sel         <= itp_pkg::ITP_SEL_RESET;
         st_reg.promote     <= itp_pkg::ITP_PROMOTE_RESET;
         st_reg.last_vec    <= itp_pkg::ITP_SWI_VEC_BYTE;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rdata_o     = st_reg.rdata;
   assign vec_o       = st_reg.vec;
   assign vec_valid_o = st_reg.vec_valid;
   assign pending_o   = dec_any;

   a_override_reset: assert property (@(posedge clk_i) $rose(arst_n_i) |-> !st_reg.override_en)
      else $error("override set after reset");
   a_override_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      $rose(st_reg.override_en) |-> $past(cpu_i.special_mode && cpu_i.i_mask && cpu_i.x_mask))
      else $error("override set without permission");
   a_bank_nowrite: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (wr_bank && !st_reg.override_en && !wr_ctl) |=> st_reg.test_bits == $past(st_reg.test_bits))
      else $error("bank written while override clear");
   a_normal_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (bus_i.rd && bus_i.addr == itp_pkg::ITP_TEST_BANK_OFS && !cpu_i.special_mode) |=> rdata_o == 8'h00)
      else $error("bank read nonzero in normal mode");
   a_top_bank: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (bus_i.rd && bus_i.addr == itp_pkg::ITP_TEST_BANK_OFS && st_reg.sel == itp_pkg::ITP_TOP_BANK)
      |=> rdata_o[7:3] == 5'h00)
      else $error("top bank high bits nonzero");
   a_prom_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (st_reg.promote != $past(st_reg.promote)) |-> $past(wr_prom && cpu_i.i_mask))
      else $error("promotion written without mask");
   a_vec_time: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (vec_req_i && dec_any) |=> (vec_valid_o && vec_o == $past(dec_vec)))
      else $error("vector not returned next cycle");
   a_override_src: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      st_reg.override_en |-> pending_o == (|st_reg.test_bits))
      else $error("decoder not fed from test bits");

   // Register side: every write either lands exactly or leaves state alone.
   // Reads are checked one cycle on, against the state seen at the strobe.
   a_ctl_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (wr_ctl && ctl_ok) |=> st_reg.override_en == $past(bus_i.wdata[itp_pkg::ITP_OVERRIDE_BIT]))
      else $error("override write lost");

   a_ctl_locked: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (wr_ctl && !ctl_ok) |=> $stable(st_reg.override_en))
      else $error("override changed while locked");

   a_override_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !wr_ctl |=> $stable(st_reg.override_en))
      else $error("override changed without write");

   a_ctl_read: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (bus_i.rd && bus_i.addr == itp_pkg::ITP_TEST_CONTROL_OFS)
      |=> rdata_o == {3'h0, $past(st_reg.override_en), $past(st_reg.sel)})
      else $error("control read wrong");

   a_sel_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      wr_ctl |=> st_reg.sel == $past(bus_i.wdata[itp_pkg::ITP_SEL_MSB:0]))
      else $error("selector write lost");

   a_sel_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !wr_ctl |=> $stable(st_reg.sel))
      else $error("selector changed without write");

   a_live_read: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (bus_i.rd && bus_i.addr == itp_pkg::ITP_TEST_BANK_OFS && cpu_i.special_mode && !st_reg.override_en)
      |=> rdata_o == $past(bank_of(live_req, st_reg.sel) & bmask))
      else $error("bank read not live inputs");

   a_test_read: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (bus_i.rd && bus_i.addr == itp_pkg::ITP_TEST_BANK_OFS && cpu_i.special_mode && st_reg.override_en)
      |=> rdata_o == $past(bank_of(st_reg.test_bits, st_reg.sel) & bmask))
      else $error("bank read not test bits");

   a_unmapped_bank: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (bus_i.rd && bus_i.addr == itp_pkg::ITP_TEST_BANK_OFS && int'(st_reg.sel) >= NUM_BANKS)
      |=> rdata_o == 8'h00)
      else $error("missing bank read nonzero");

   a_rd_idle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !bus_i.rd |=> rdata_o == 8'h00)
      else $error("read data without read");

   // Test bits: written only when permitted, kept otherwise
   a_bank_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (wr_bank && bank_ok)
      |=> bank_of(st_reg.test_bits, $past(st_reg.sel)) == $past(bus_i.wdata & bmask))
      else $error("bank write lost");

   a_bank_locked: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (wr_bank && !bank_ok) |=> $stable(st_reg.test_bits))
      else $error("bank written without permission");

   a_top_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (wr_bank && bank_ok && st_reg.sel == itp_pkg::ITP_TOP_BANK)
      |=> (bank_of(st_reg.test_bits, itp_pkg::ITP_TOP_BANK) & ~itp_pkg::ITP_TOP_BANK_MASK) == 8'h00)
      else $error("top bank high bits written");

   a_capture: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (wr_ctl && ctl_ok && bus_i.wdata[itp_pkg::ITP_OVERRIDE_BIT] && !st_reg.override_en)
      |=> st_reg.test_bits == $past(live_req))
      else $error("pending requests not captured");

   a_keep_pending: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (st_reg.override_en && !(wr_bank && bank_ok)) |=> $stable(st_reg.test_bits))
      else $error("test bits changed without write");

   a_live_src: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !st_reg.override_en |-> pending_o == (|live_req))
      else $error("decoder not fed from live inputs");

   // Promotion register
   a_prom_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (wr_prom && prom_ok) |=> st_reg.promote == $past(bus_i.wdata))
      else $error("promotion write lost");

   a_prom_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !(wr_prom && prom_ok) |=> $stable(st_reg.promote))
      else $error("promotion changed without write");

   a_prom_read: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (bus_i.rd && bus_i.addr == itp_pkg::ITP_PROMOTE_OFS) |=> rdata_o == $past(st_reg.promote))
      else $error("promotion read wrong");

   // Vector side: one answer per request, held until the next one
   a_vec_valid: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      vec_req_i |=> vec_valid_o)
      else $error("vector request unanswered");

   a_vec_quiet: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !vec_req_i |=> (!vec_valid_o && $stable(vec_o)))
      else $error("vector moved without request");

   a_vec_fallback: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (vec_req_i && !dec_any) |=> vec_o == $past(st_reg.last_vec))
      else $error("fallback vector wrong");

   a_last_track: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      dec_any |=> st_reg.last_vec == $past(dec_vec))
      else $error("last valid vector not kept");

   a_promoted_wins: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (vec_req_i && st_reg.promote <= itp_pkg::ITP_PIN_VEC_BYTE && !st_reg.promote[0]
       && dec_req[st_reg.promote[7:1]]) |=> vec_o == $past(st_reg.promote))
      else $error("promoted source did not win");

   a_pin_default: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (vec_req_i && (st_reg.promote > itp_pkg::ITP_PIN_VEC_BYTE || st_reg.promote[0])
       && dec_req[itp_pkg::ITP_PIN_VEC_BYTE[7:1]]) |=> vec_o == itp_pkg::ITP_PIN_VEC_BYTE)
      else $error("pin not promoted by default");
endmodule : itp_top
`default_nettype wire

// File: verilog/itp_pkg.sv
// Package for the interrupt test and priority select block.
// Assumes one 200 MHz clock domain and a byte-wide register port.
package itp_pkg;

   localparam logic [7:0] ITP_TEST_CONTROL_OFS  = 8'h15;
   localparam logic [7:0] ITP_TEST_BANK_OFS     = 8'h16;
   localparam logic [7:0] ITP_PROMOTE_OFS       = 8'h1f;

   localparam int          ITP_OVERRIDE_BIT      = 4;
   localparam int          ITP_SEL_MSB           = 3;
   localparam logic [3:0]  ITP_SEL_RESET         = 4'h0;
   localparam logic        ITP_OVERRIDE_RESET    = 1'b0;
   // Low vector byte of the maskable pin interrupt, the top maskable source
   localparam logic [7:0]  ITP_PIN_VEC_BYTE      = 8'hf2;
   localparam logic [7:0]  ITP_PROMOTE_RESET     = 8'hf2;
   localparam logic [7:0]  ITP_SWI_VEC_BYTE      = 8'hf6;
   localparam logic [3:0]  ITP_TOP_BANK          = 4'hf;
   localparam logic [7:0]  ITP_TOP_BANK_MASK     = 8'h07;
   localparam int          ITP_BANKS_MAX         = 16;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } itp_bus_t;

   typedef struct packed {
      logic special_mode;
      logic i_mask;
      logic x_mask;
   } itp_cpu_t;

endpackage : itp_pkg

// File: verilog/itp_sync.sv
// Two-flop synchroniser for a vector of request pins.
// Assumes the pins are asynchronous to clk_i.
`timescale 1ns/10ps
`default_nettype none
module itp_sync #(
   parameter int W = 8
) (
   input  wire logic         clk_i,
   input  wire logic         arst_n_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } itp_sync_state_t;

   itp_sync_state_t st_reg;
   itp_sync_state_t st_next;

   always_comb begin
      st_next    = st_reg;
      st_next.s1 = async_i;
      st_next.s2 = st_reg.s1;
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sync_o = st_reg.s2;
endmodule : itp_sync
`default_nettype wire

// File: verilog/itp_prio_dec.sv
// Priority decoder over the maskable request vector.
// Assumes requests index vector low byte = 2*index; index 121 is the pin.
`timescale 1ns/10ps
`default_nettype none
module itp_prio_dec #(
   parameter int N = 128
) (
   input  wire logic [N-1:0] req_i,
   input  wire logic [7:0]   promote_i,
   output logic              any_o,
   output logic      [7:0]   vec_o
);
   logic [7:0] pidx;
   logic       pvalid;

   always_comb begin
      // Odd bytes, unimplemented or non-maskable entries fall back to the pin
      pvalid = (promote_i <= itp_pkg::ITP_PIN_VEC_BYTE) && !promote_i[0]
               && (int'(promote_i[7:1]) < N);
      pidx   = pvalid ? {1'b0, promote_i[7:1]} : {1'b0, itp_pkg::ITP_PIN_VEC_BYTE[7:1]};
      any_o  = |req_i;
      vec_o  = itp_pkg::ITP_SWI_VEC_BYTE;
      for (int k = 0; k < N; k++) begin
         if (req_i[k]) begin
            vec_o = 8'(2 * k);
         end
      end
      if (int'(pidx) < N && req_i[pidx[6:0]]) begin
         vec_o = {pidx[6:0], 1'b0};
      end
   end
endmodule : itp_prio_dec
`default_nettype wire

// File: verif/itp_cpu_model.sv
// Model of the CPU core: register accesses, mode and mask levels, vector requests.
// Assumes the block answers reads and vectors exactly one cycle after the strobe.
`timescale 1ns/10ps
`default_nettype none
module itp_cpu_model (
   input  wire logic            clk_i,
   output var itp_pkg::itp_bus_t bus_o,
   output var itp_pkg::itp_cpu_t cpu_o,
   output logic                 vec_req_o,
   input  wire logic [7:0]      rdata_i,
   input  wire logic [7:0]      vec_i,
   input  wire logic            vld_i
);
   initial begin
      bus_o = '0;
      cpu_o = '0;
      vec_req_o = 1'b0;
   end
   task automatic mode(input logic s, input logic i, input logic x);
      @(posedge clk_i);
      cpu_o <= {s, i, x};
   endtask : mode
   // Idle data lines toggle so a stale value is never mistaken for a live one
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      bus_o.wr <= 1'b1;
      bus_o.addr <= a;
      bus_o.wdata <= d;
      @(posedge clk_i);
      bus_o.wr <= 1'b0;
      bus_o.wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      bus_o.rd <= 1'b1;
      bus_o.addr <= a;
      @(posedge clk_i);
      bus_o.rd <= 1'b0;
      #1 d = rdata_i;
   endtask : rd
   task automatic vec(output logic [7:0] v, output logic ok);
      @(posedge clk_i);
      vec_req_o <= 1'b1;
      @(posedge clk_i);
      vec_req_o <= 1'b0;
      #1 v = vec_i;
      ok = vld_i;
   endtask : vec
endmodule : itp_cpu_model
`default_nettype wire

// File: verif/interrupt_test_and_priority_select_bench.sv
// Self-checking bench for the interrupt test and priority select block.
// Assumes the CPU model drives all bus, mode and vector inputs.
`timescale 1ns/10ps
`default_nettype none
module interrupt_test_and_priority_select_bench;
   logic              clk;
   logic              arst_n;
   logic [127:0]      pins;
   itp_pkg::itp_bus_t bus;
   itp_pkg::itp_cpu_t cpu;
   logic              vreq;
   logic [7:0]        rdata;
   logic [7:0]        vec;
   logic [7:0]        d;
   logic              vvalid;
   logic              pend;
   logic              ok;
   int                err_total;
   int                tests_run;
   itp_top #(.NUM_BANKS(16)) u_dut (.clk_i(clk), .arst_n_i(arst_n), .bus_i(bus), .rdata_o(rdata),
      .cpu_i(cpu), .irq_pins_i(pins), .vec_req_i(vreq), .vec_o(vec), .vec_valid_o(vvalid), .pending_o(pend));
   itp_cpu_model u_cpu (.clk_i(clk), .bus_o(bus), .cpu_o(cpu), .vec_req_o(vreq), .rdata_i(rdata),
      .vec_i(vec), .vld_i(vvalid));
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      u_cpu.rd(a, v);
      check("register read", v, exp);
   endtask : rd_chk
   task automatic vec_chk(input logic [7:0] exp);
      logic [7:0] v;
      logic       k;
      u_cpu.vec(v, k);
      check("vector", v, exp);
      check("vector valid", {7'h00, k}, 8'h01);
   endtask : vec_chk
   // Two synchroniser flops plus margin before pins are seen
   task automatic set_pins(input logic [127:0] p);
      @(posedge clk);
      pins <= p;
      repeat (4) @(posedge clk);
   endtask : set_pins
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      #100000;
      err_total++;
      complete_run();
   end
   initial begin
      arst_n = 1'b0;
      pins = '0;
      err_total = 0;
      tests_run = 0;
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      rd_chk(8'h15, 8'h00);
      rd_chk(8'h1f, 8'hf2);
      check("pending", {7'h00, pend}, 8'h00);
      vec_chk(8'hf6);
      $display("reset test done");
      set_pins(128'h5a << 24);
      u_cpu.mode(1'b0, 1'b1, 1'b1);
      u_cpu.wr(8'h15, 8'h13);
      rd_chk(8'h15, 8'h03);
      rd_chk(8'h16, 8'h00);
      u_cpu.mode(1'b1, 1'b1, 1'b0);
      u_cpu.wr(8'h15, 8'h13);
      rd_chk(8'h15, 8'h03);
      rd_chk(8'h16, 8'h5a);
      u_cpu.wr(8'h16, 8'hff);
      rd_chk(8'h16, 8'h5a);
      vec_chk(8'h3c);
      $display("live input test done");
      u_cpu.mode(1'b1, 1'b1, 1'b1);
      u_cpu.wr(8'h15, 8'h13);
      rd_chk(8'h15, 8'h13);
      set_pins(128'h0);
      rd_chk(8'h16, 8'h5a);
      check("pending", {7'h00, pend}, 8'h01);
      vec_chk(8'h3c);
      u_cpu.mode(1'b1, 1'b0, 1'b1);
      u_cpu.wr(8'h16, 8'h81);
      rd_chk(8'h16, 8'h5a);
      u_cpu.mode(1'b1, 1'b1, 1'b1);
      u_cpu.wr(8'h16, 8'h81);
      rd_chk(8'h16, 8'h81);
      vec_chk(8'h3e);
      $display("override test done");
      u_cpu.mode(1'b1, 1'b0, 1'b1);
      u_cpu.wr(8'h1f, 8'h30);
      rd_chk(8'h1f, 8'hf2);
      u_cpu.mode(1'b1, 1'b1, 1'b1);
      u_cpu.wr(8'h1f, 8'h30);
      rd_chk(8'h1f, 8'h30);
      vec_chk(8'h30);
      // Pin interrupt is not pending, so a fallback to it yields the natural winner
      foreach (d[i]) begin
         if (i < 2) begin
            u_cpu.wr(8'h1f, (i == 0) ? 8'h31 : 8'hf8);
            vec_chk(8'h3e);
         end
      end
      $display("promotion test done");
      u_cpu.wr(8'h15, 8'h1f);
      rd_chk(8'h15, 8'h1f);
      u_cpu.wr(8'h16, 8'hff);
      rd_chk(8'h16, 8'h07);
      u_cpu.wr(8'h16, 8'h00);
      u_cpu.mode(1'b0, 1'b1, 1'b1);
      rd_chk(8'h16, 8'h00);
      rd_chk(8'h20, 8'h00);
      u_cpu.mode(1'b1, 1'b1, 1'b1);
      u_cpu.wr(8'h15, 8'h02);
      set_pins(128'h2 << 16);
      rd_chk(8'h16, 8'h02);
      vec_chk(8'h22);
      $display("bank select test done");
      complete_run();
   end
endmodule : interrupt_test_and_priority_select_bench
`default_nettype wire
